// *** vds_decode.sv ***
/*
 Opcode classifier: instruction kind and length in DWORDs.
 Assumes a purely combinational use beside the fetch logic.
*/
`timescale 1ns/1ps
module vds_decode
(
	// Opcode in
	input wire logic [3:0] op,
	// Classification out
	output vds_pkg::vds_kind_t kind,
	output logic [2:0] len
);

	always_comb
	begin
		case (op)
			vds_pkg::OP_WRITE: begin kind = vds_pkg::K_WRITE; len = 3'h2; end
			vds_pkg::OP_CONT_WRITE: begin kind = vds_pkg::K_CONT_WRITE; len = 3'h1; end
			vds_pkg::OP_SKIP: begin kind = vds_pkg::K_SKIP; len = 3'h1; end
			vds_pkg::OP_JUMP: begin kind = vds_pkg::K_JUMP; len = 3'h2; end
			vds_pkg::OP_SYNC: begin kind = vds_pkg::K_SYNC; len = 3'h2; end
			vds_pkg::OP_PWRITE: begin kind = vds_pkg::K_PWRITE; len = 3'h5; end
			vds_pkg::OP_PDWRITE: begin kind = vds_pkg::K_PDWRITE; len = 3'h5; end
			vds_pkg::OP_PSKIP: begin kind = vds_pkg::K_PSKIP; len = 3'h2; end
			default: begin kind = vds_pkg::K_ILLEGAL; len = 3'h1; end
		endcase
	end

endmodule : vds_decode

// *** vds_far_model.sv ***
/*
 Far-side model: program memory, three pixel FIFOs and a write target.
 Assumes the sequencer's fetch, FIFO and write master ports on one clock.
*/
`timescale 1ns/1ps
module vds_far_model
(
	// Clock
	input wire logic ref_clk,
	// Fetch
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	output logic fetch_ack,
	output logic [31:0] fetch_data,
	// Pixel FIFOs
	output logic fifo_valid,
	output vds_pkg::vds_pix_t fifo_word,
	input wire logic fifo_take,
	input wire logic [1:0] fifo_sel,
	// Write target
	input wire logic out_valid,
	input wire vds_pkg::vds_beat_t out_beat,
	output logic out_ready,
	// Events and pacing
	input wire logic instr_irq,
	input wire logic slow
);
	logic [31:0] mem [1024];
	vds_pkg::vds_pix_t fq [3][$];
	vds_pkg::vds_beat_t beats [$];
	logic tick = 1'b0;
	int irq_count = 0;

	// Slow mode answers every other cycle
	assign fetch_ack = fetch_req && (!slow || tick);
	assign fetch_data = fetch_ack ? mem[fetch_addr[11:2]] : ~mem[fetch_addr[11:2]];
	assign out_ready = !slow || !tick;

	// Empty FIFO shows a pattern that changes every cycle
	always @*
	begin
		fifo_valid = 1'b0;
		fifo_word = tick ? '1 : '0;
		if (fifo_sel != 2'h3 && fq[fifo_sel].size() != 0)
		begin
			fifo_valid = 1'b1;
			fifo_word = fq[fifo_sel][0];
		end
	end

	always @(posedge ref_clk)
	begin
		tick <= ~tick;
		if (fifo_take && fifo_valid)
		begin
			void'(fq[fifo_sel].pop_front());
		end
		if (out_valid && out_ready)
		begin
			beats.push_back(out_beat);
		end
		if (instr_irq)
		begin
			irq_count++;
		end
	end

	task load(input logic [31:0] a, input logic [31:0] w);
		mem[a[11:2]] = w;
	endtask : load

	task push(input int s, input logic [31:0] d, input logic [3:0] st, input logic e);
		fq[s].push_back({d, st, e});
	endtask : push

	initial
	begin
		foreach (mem[i])
		begin
			mem[i] = 32'h0000_0000;
		end
	end
endmodule : vds_far_model

// *** vds_pkg.sv ***
/*
 Shared constants and types of the video DMA program sequencer.
 Assumes every user references names as vds_pkg::name, with no import.
*/
package vds_pkg;

	// Opcodes
	localparam logic [3:0] OP_WRITE = 4'h1;
	localparam logic [3:0] OP_SKIP = 4'h2;
	localparam logic [3:0] OP_CONT_WRITE = 4'h5;
	localparam logic [3:0] OP_JUMP = 4'h7;
	localparam logic [3:0] OP_SYNC = 4'h8;
	localparam logic [3:0] OP_PWRITE = 4'h9;
	localparam logic [3:0] OP_PSKIP = 4'ha;
	localparam logic [3:0] OP_PDWRITE = 4'hb;

	// Instruction field positions
	localparam int OP_LSB = 28;
	localparam int LF_BIT = 27;
	localparam int LL_BIT = 26;
	localparam int IRQ_BIT = 24;
	localparam int PSET_LSB = 20;
	localparam int PCLR_LSB = 16;
	localparam int SUPP_BIT = 15;
	localparam int CNT_W = 12;
	localparam int MAX_WORDS = 5;

	// Register map
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_START = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_PC = 5'h0c;
	localparam logic [4:0] REG_PFLAGS = 5'h10;
	localparam int CTRL_RUN = 0;
	localparam int ST_ERR = 0;
	localparam int ST_MISM = 1;
	localparam int ST_DONE = 2;
	localparam int ST_HALT = 3;
	localparam logic [31:0] START_RST = 32'h0000_0000;
	localparam logic [15:0] SYNC_VALID_RST = 16'h7ffe;

	typedef enum logic [3:0] {
		K_ILLEGAL = 4'h0, K_WRITE = 4'h1, K_CONT_WRITE = 4'h2, K_SKIP = 4'h3, K_JUMP = 4'h4,
		K_SYNC = 4'h5, K_PWRITE = 4'h6, K_PDWRITE = 4'h7, K_PSKIP = 4'h8
	} vds_kind_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_FETCH = 3'h1, S_DECODE = 3'h2, S_SYNC = 3'h3, S_MOVE = 3'h4,
		S_HALT = 3'h5
	} vds_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] status;
		logic line_last_flag;
	} vds_pix_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] be;
	} vds_beat_t;

endpackage : vds_pkg

// *** vds_sequencer.sv ***
/*
 Program sequencer of a video capture DMA engine: fetch, check, align, move.
 Assumes a same-clock memory read port, pixel FIFO port and write master.
 // Function
 // - Branch, two words, opcode 0111, loads PC from word one, aligned
 // - Branch redirects fetch without touching pixel flow
 // - Align, opcode 1000, consumes FIFO until its 4-bit code matches FIFO status
 // - Align bit 15 set suppresses stream mismatch error reporting
 // - Discard FIFO data before match, then continue with following instructions
 // - Fetch handles instructions of one to five words
 // - Line-first flag marks first instruction of a scan line
 // - Line-last instruction ends with the FIFO end-of-line marker
 // - Early FIFO end-of-line aborts instructions through the line-last one
 // - Packed mode moves or drops data only by write, continued write, discard
 // - Continued write uses target address counter, also advanced by discards
 // - Planar instructions process equal byte counts from second and third FIFOs
 // - Chroma-decimating planar write drops chroma on alternate lines
 // - Opcodes 0000, 1111 and unassigned ones are instruction errors
 // - Instruction error halts until software re-enables execution
 // - Align with reserved status code is an instruction error
*/
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module vds_sequencer #(
	parameter logic [15:0] SYNC_VALID = vds_pkg::SYNC_VALID_RST
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Instruction fetch
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	input wire logic fetch_ack,
	input wire logic [31:0] fetch_data,
	// Pixel FIFO
	input wire logic fifo_valid,
	input wire vds_pkg::vds_pix_t fifo_word,
	output logic fifo_take,
	output logic [1:0] fifo_sel,
	// Write master
	output logic out_valid,
	output vds_pkg::vds_beat_t out_beat,
	input wire logic out_ready,
	// Events
	output logic instr_irq,
	output logic instr_error,
	output logic [3:0] program_status_flags
);

	vds_pkg::vds_state_t state;
	vds_pkg::vds_kind_t kind;
	logic [2:0] len;
	logic [2:0] widx;
	logic [vds_pkg::MAX_WORDS-1:0][31:0] w;
	logic [31:0] pc;
	logic [31:0] start_pc;
	logic run;
	logic [31:0] tac;
	logic [31:0] cur_addr;
	logic [vds_pkg::CNT_W-1:0] rem;
	logic [1:0] phase;
	logic flushing;
	logic suppress;
	logic chroma_line;
	logic err_flag;
	logic mism_flag;
	logic done_flag;
	logic retire;
	logic err_set;
	logic mism_set;
	logic move_take;
	logic writing;
	logic planar;
	logic last_beat;
	logic phase_end;
	logic instr_end;
	logic run_start;
	logic [2:0] nb;
	logic [3:0] be;
	logic [3:0] op_in;

	assign run_start = reg_wr && reg_addr == vds_pkg::REG_CTRL && reg_wdata[vds_pkg::CTRL_RUN];

	// Opcode from the incoming first word or from the buffer
	assign op_in = (state == vds_pkg::S_FETCH && widx == 3'h0) ?
		fetch_data[31:vds_pkg::OP_LSB] : w[0][31:vds_pkg::OP_LSB];

	vds_decode u_decode
	(
		.op(op_in),
		.kind(kind),
		.len(len)
	);

	vds_wbuf #(
		.DEPTH(vds_pkg::MAX_WORDS)
	) u_wbuf
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(state == vds_pkg::S_FETCH && fetch_ack),
		.wr_idx(widx),
		.wr_data(fetch_data),
		.words(w)
	);

	assign planar = kind == vds_pkg::K_PWRITE || kind == vds_pkg::K_PDWRITE
		|| kind == vds_pkg::K_PSKIP;
	// Chroma phases of the decimating write are dropped on alternate lines
	assign writing = (kind == vds_pkg::K_WRITE || kind == vds_pkg::K_CONT_WRITE
		|| kind == vds_pkg::K_PWRITE
		|| (kind == vds_pkg::K_PDWRITE && (phase == 2'h0 || chroma_line)));
	assign nb = (rem >= 12'h004) ? 3'h4 : rem[2:0];
	assign be = (rem >= 12'h004) ? 4'hf : ((rem[1:0] == 2'h3) ? 4'h7 :
		((rem[1:0] == 2'h2) ? 4'h3 : 4'h1));
	assign move_take = state == vds_pkg::S_MOVE && rem != 12'h000 && fifo_valid
		&& (!writing || !out_valid || out_ready);
	assign last_beat = move_take && rem <= 12'h004;
	assign phase_end = (state == vds_pkg::S_MOVE && rem == 12'h000) || last_beat;
	assign instr_end = phase_end && (!planar || phase == 2'h2);

	// Consume: discard until align match, or move a beat
	assign fifo_take = move_take || (state == vds_pkg::S_SYNC && fifo_valid
		&& fifo_word.status != w[0][3:0]);
	assign fifo_sel = planar ? phase : 2'h0;
	assign fetch_req = state == vds_pkg::S_FETCH;
	assign fetch_addr = pc;

	// Retire and error events
	always_comb
	begin
		retire = 1'b0;
		err_set = 1'b0;
		mism_set = 1'b0;
		if (state == vds_pkg::S_DECODE)
		begin
			if (kind == vds_pkg::K_ILLEGAL)
				err_set = 1'b1;
			else if (kind == vds_pkg::K_SYNC && !SYNC_VALID[w[0][3:0]])
				err_set = 1'b1;
			else if (kind == vds_pkg::K_JUMP || (flushing && kind != vds_pkg::K_SYNC))
				retire = 1'b1;
		end
		if (state == vds_pkg::S_SYNC && fifo_valid && fifo_word.status == w[0][3:0])
			retire = 1'b1;
		if (instr_end)
			retire = 1'b1;
		// Line end before the line-last instruction completes, unless suppressed
		if (move_take && fifo_word.line_last_flag && !(instr_end && w[0][vds_pkg::LL_BIT]) && !suppress)
			mism_set = 1'b1;
	end

	// Main state machine
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= vds_pkg::S_IDLE;
		else if (run_start)
			state <= vds_pkg::S_FETCH;
		else if (!run)
			state <= vds_pkg::S_IDLE;
		else
		begin
			case (state)
				vds_pkg::S_IDLE: state <= vds_pkg::S_IDLE;
				vds_pkg::S_FETCH:
					if (fetch_ack && widx + 3'h1 >= len)
						state <= vds_pkg::S_DECODE;
				vds_pkg::S_DECODE:
					if (err_set)
						state <= vds_pkg::S_HALT;
					else if (kind == vds_pkg::K_SYNC)
						state <= vds_pkg::S_SYNC;
					else if (retire)
						state <= vds_pkg::S_FETCH;
					else
						state <= vds_pkg::S_MOVE;
				vds_pkg::S_SYNC:
					if (retire)
						state <= vds_pkg::S_FETCH;
				vds_pkg::S_MOVE:
					if (instr_end || (move_take && fifo_word.line_last_flag))
						state <= vds_pkg::S_FETCH;
				vds_pkg::S_HALT: state <= vds_pkg::S_HALT;
				default: state <= vds_pkg::S_IDLE;
			endcase
		end
	end

	// Fetch word index and program counter
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			widx <= 3'h0;
			pc <= vds_pkg::START_RST;
		end
		else if (run_start)
		begin
			widx <= 3'h0;
			pc <= {start_pc[31:2], 2'b00};
		end
		else if (state == vds_pkg::S_FETCH && fetch_ack)
		begin
			widx <= (widx + 3'h1 >= len) ? 3'h0 : widx + 3'h1;
			pc <= pc + 32'h4;
		end
		else if (state == vds_pkg::S_DECODE && kind == vds_pkg::K_JUMP && !flushing)
			pc <= {w[1][31:2], 2'b00};
	end

	// Flush after an early line end, align suppress and chroma line parity
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flushing <= 1'b0;
			suppress <= 1'b0;
			chroma_line <= 1'b1;
		end
		else if (run_start)
		begin
			flushing <= 1'b0;
			chroma_line <= 1'b1;
		end
		else
		begin
			if (state == vds_pkg::S_DECODE && kind == vds_pkg::K_SYNC && !err_set)
			begin
				suppress <= w[0][vds_pkg::SUPP_BIT];
				flushing <= 1'b0;
			end
			else if (state == vds_pkg::S_DECODE && flushing && w[0][vds_pkg::LL_BIT])
				flushing <= 1'b0;
			else if (move_take && fifo_word.line_last_flag && !w[0][vds_pkg::LL_BIT])
				flushing <= 1'b1;
			// A completed line-last decimating planar write flips the chroma line parity
			if (instr_end && w[0][vds_pkg::LL_BIT] && kind == vds_pkg::K_PDWRITE)
				chroma_line <= !chroma_line;
		end
	end

	// Byte counter, phase and addresses
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rem <= '0;
			phase <= 2'h0;
			cur_addr <= 32'h0000_0000;
			tac <= 32'h0000_0000;
		end
		else if (state == vds_pkg::S_DECODE)
		begin
			phase <= 2'h0;
			rem <= w[0][vds_pkg::CNT_W-1:0];
			if (kind == vds_pkg::K_WRITE)
				tac <= w[1];
			if (planar)
				cur_addr <= w[2];
		end
		else if (phase_end && !instr_end)
		begin
			phase <= phase + 2'h1;
			rem <= w[1][vds_pkg::CNT_W-1:0];
			cur_addr <= (phase == 2'h0) ? w[3] : w[4];
		end
		else if (move_take)
		begin
			rem <= rem - {9'h000, nb};
			if (planar)
				cur_addr <= cur_addr + {29'h0, nb};
			else
				tac <= tac + {29'h0, nb};
		end
	end

	// Output beat register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_beat <= '0;
		end
		else if (move_take && writing)
		begin
			out_valid <= 1'b1;
			out_beat.addr <= planar ? cur_addr : tac;
			out_beat.data <= fifo_word.data;
			out_beat.be <= be;
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end

	// Completion interrupt pulse and program status flags
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_irq <= 1'b0;
			program_status_flags <= 4'h0;
		end
		else
		begin
			instr_irq <= retire && w[0][vds_pkg::IRQ_BIT];
			if (retire)
				program_status_flags <= (program_status_flags
					& ~w[0][vds_pkg::PCLR_LSB+:4]) | w[0][vds_pkg::PSET_LSB+:4];
		end
	end

	// Control registers and sticky status, set wins over clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run <= 1'b0;
			start_pc <= vds_pkg::START_RST;
			err_flag <= 1'b0;
			mism_flag <= 1'b0;
			done_flag <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == vds_pkg::REG_CTRL)
				run <= reg_wdata[vds_pkg::CTRL_RUN];
			if (reg_wr && reg_addr == vds_pkg::REG_START)
				start_pc <= reg_wdata;
			if (err_set)
				err_flag <= 1'b1;
			else if (reg_wr && reg_addr == vds_pkg::REG_STATUS && reg_wdata[vds_pkg::ST_ERR])
				err_flag <= 1'b0;
			if (mism_set)
				mism_flag <= 1'b1;
			else if (reg_wr && reg_addr == vds_pkg::REG_STATUS && reg_wdata[vds_pkg::ST_MISM])
				mism_flag <= 1'b0;
			if (retire && w[0][vds_pkg::IRQ_BIT])
				done_flag <= 1'b1;
			else if (reg_wr && reg_addr == vds_pkg::REG_STATUS && reg_wdata[vds_pkg::ST_DONE])
				done_flag <= 1'b0;
		end
	end
	assign instr_error = err_flag;

	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				vds_pkg::REG_CTRL: reg_rdata <= {31'h0, run};
				vds_pkg::REG_START: reg_rdata <= start_pc;
				vds_pkg::REG_STATUS: reg_rdata <= {28'h0, state == vds_pkg::S_HALT,
					done_flag, mism_flag, err_flag};
				vds_pkg::REG_PC: reg_rdata <= pc;
				vds_pkg::REG_PFLAGS: reg_rdata <= {28'h0, program_status_flags};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

	// Checks
	sequence s_error_seen;
		state == vds_pkg::S_DECODE && err_set;
	endsequence
	sequence s_halted_hold;
		(state == vds_pkg::S_HALT && err_flag) [*2];
	endsequence

	jump_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == vds_pkg::S_DECODE && kind == vds_pkg::K_JUMP && !flushing && run && !run_start
		|=> pc == {$past(w[1][31:2]), 2'b00} && state == vds_pkg::S_FETCH)
		else $error("branch did not load program counter");
	jump_noflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == vds_pkg::S_DECODE && kind == vds_pkg::K_JUMP
		|-> !fifo_take ##1 (out_valid || !$past(out_valid) || $past(out_ready)))
		else $error("branch disturbed pixel flow");
	sync_discard_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == vds_pkg::S_SYNC && fifo_valid && fifo_word.status != w[0][3:0]
		|-> fifo_take ##1 !(out_valid && !$past(out_valid)))
		else $error("align did not discard data");
	sync_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == vds_pkg::S_SYNC && fifo_valid && fifo_word.status == w[0][3:0] && !run_start
		&& run |-> !fifo_take ##1 state == vds_pkg::S_FETCH)
		else $error("align match did not resume program");
	suppress_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mism_set |-> !suppress ##1 mism_flag)
		else $error("mismatch reported while suppressed");
	error_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_error_seen ##1 (!run_start && run) [*2] |-> state == vds_pkg::S_HALT && !fetch_req)
		else $error("error did not halt");
	illegal_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_error_seen ##1 !run_start && run |-> s_halted_hold or ##1 run_start or ##1 !run)
		else $error("illegal opcode not halted");
	fetch_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == vds_pkg::S_FETCH && fetch_ack && widx + 3'h1 >= len && run && !run_start
		|=> state == vds_pkg::S_DECODE && widx == 3'h0 && $past(len) inside {[3'h1:3'h5]})
		else $error("instruction length not honoured");
	cont_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		move_take && writing && kind == vds_pkg::K_CONT_WRITE
		|=> out_valid && out_beat.addr == $past(tac))
		else $error("continued write not at target counter");
	early_eol_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		move_take && fifo_word.line_last_flag && !w[0][vds_pkg::LL_BIT] && !run_start && run
		|=> flushing && state == vds_pkg::S_FETCH)
		else $error("early line end did not abort");

endmodule : vds_sequencer

// *** vds_sequencer_test.sv ***
/*
 Self-checking bench of the program sequencer, register tasks and program runs.
 Assumes vds_pkg, vds_sequencer and vds_far_model are compiled before it.
*/
`timescale 1ns/1ps
module vds_sequencer_test;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow = 1'b0;
	logic [31:0] reg_rdata, fetch_addr, fetch_data;
	logic fetch_req, fetch_ack, fifo_valid, fifo_take, out_valid, out_ready;
	logic instr_irq, instr_error;
	logic [1:0] fifo_sel;
	logic [3:0] program_status_flags;
	vds_pkg::vds_pix_t fifo_word;
	vds_pkg::vds_beat_t out_beat;
	int bad_count = 0;
	int comparisons = 0;
	logic [3:0] bad_ops [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'hc, 4'hd, 4'he, 4'hf};

	always #5 ref_clk = ~ref_clk;

	vds_sequencer vds_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
		.fetch_data(fetch_data), .fifo_valid(fifo_valid), .fifo_word(fifo_word),
		.fifo_take(fifo_take), .fifo_sel(fifo_sel), .out_valid(out_valid), .out_beat(out_beat),
		.out_ready(out_ready), .instr_irq(instr_irq), .instr_error(instr_error),
		.program_status_flags(program_status_flags));

	vds_far_model vds_far_model_inst (.ref_clk(ref_clk), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
		.fifo_valid(fifo_valid), .fifo_word(fifo_word), .fifo_take(fifo_take),
		.fifo_sel(fifo_sel), .out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready),
		.instr_irq(instr_irq), .slow(slow));

	task conclude;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task reg_read(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, exp);
	endtask : reg_read

	task run(input logic [31:0] start);
		reg_write(vds_pkg::REG_CTRL, 32'h0000_0000);
		reg_write(vds_pkg::REG_STATUS, 32'h0000_000f);
		vds_far_model_inst.beats.delete();
		reg_write(vds_pkg::REG_START, start);
		reg_write(vds_pkg::REG_CTRL, 32'h0000_0001);
	endtask : run

	task wait_err;
		int n;
		n = 0;
		while (instr_error !== 1'b1 && n < 3000)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 3000)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t sequencer never stopped", $time);
			conclude();
		end
	endtask : wait_err

	task chk_beat(input int i, input logic [31:0] a, input logic [31:0] d);
		if (i >= vds_far_model_inst.beats.size())
			chk(32'hdead_0000, a);
		else
		begin
			chk(vds_far_model_inst.beats[i].addr, a);
			chk(vds_far_model_inst.beats[i].data, d);
			chk({28'h0, vds_far_model_inst.beats[i].be}, 32'h0000_000f);
		end
	endtask : chk_beat

	task prog(input logic [31:0] a, input logic [31:0] w [$]);
		foreach (w[i])
		begin
			vds_far_model_inst.load(a + 32'(4 * i), w[i]);
		end
	endtask : prog

	initial
	begin
		int busy;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Reset values and an unmapped place
		reg_read(vds_pkg::REG_STATUS, '1, 32'h0000_0000);
		reg_read(vds_pkg::REG_PC, '1, 32'h0000_0000);
		reg_read(vds_pkg::REG_START, '1, vds_pkg::START_RST);
		reg_write(5'h14, 32'hffff_ffff);
		reg_read(5'h14, '1, 32'h0000_0000);
		// Align, write, continued writes around a discard, branch, then a bad opcode
		prog(32'h100, '{32'h8000_0003, 0, 32'h1910_0008, 32'h2000, 32'h5000_0004, 32'h2000_0004,
			32'h5400_0004, 32'h7041_0000, 32'h200});
		prog(32'h200, '{32'h0000_0000});
		vds_far_model_inst.push(0, 32'h1111_1111, 4'h1, 1'b0);
		vds_far_model_inst.push(0, 32'h2222_2222, 4'h2, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			vds_far_model_inst.push(0, 32'ha0a0_0000 + 32'(i), 4'h3, i == 4);
		end
		run(32'h100);
		wait_err();
		chk_beat(0, 32'h2000, 32'ha0a0_0000);
		chk_beat(1, 32'h2004, 32'ha0a0_0001);
		chk_beat(2, 32'h2008, 32'ha0a0_0002);
		chk_beat(3, 32'h2010, 32'ha0a0_0004);
		chk(vds_far_model_inst.irq_count, 1);
		chk({28'h0, program_status_flags}, 32'h0000_0004);
		reg_read(vds_pkg::REG_PFLAGS, '1, 32'h0000_0004);
		reg_read(vds_pkg::REG_PC, 32'hffff_fff0, 32'h0000_0200);
		reg_read(vds_pkg::REG_STATUS, 32'h0000_000d, 32'h0000_000d);
		// Halted sequencer fetches nothing
		busy = 0;
		repeat (30)
		begin
			@(posedge ref_clk);
			busy += int'(fetch_req === 1'b1);
		end
		chk(busy, 0);
		// Every unassigned opcode and both reserved align codes
		for (int k = 0; k < 10; k++)
		begin
			if (k < 8)
				prog(32'h300, '{{bad_ops[k], 28'h0}});
			else
				prog(32'h300, '{k == 8 ? 32'h8000_0000 : 32'h8000_000f, 0});
			run(32'h300);
			wait_err();
			reg_read(vds_pkg::REG_STATUS, 32'h0000_0009, 32'h0000_0009);
		end
		// Early end of line, slow partner, then a planar write
		slow <= 1'b1;
		prog(32'h400, '{32'h8000_8005, 0, 32'h1800_000c, 32'h3000, 32'h5000_0004, 32'h2400_0004,
			32'h1c00_0004, 32'h4000, 32'h9c00_0004, 4, 32'h5000, 32'h6000, 32'h7000,
			32'h0});
		vds_far_model_inst.push(0, 32'h3333_3333, 4'h1, 1'b0);
		vds_far_model_inst.push(0, 32'he000_0000, 4'h5, 1'b0);
		vds_far_model_inst.push(0, 32'he000_0001, 4'h5, 1'b1);
		vds_far_model_inst.push(0, 32'hf000_0000, 4'h5, 1'b1);
		vds_far_model_inst.push(0, 32'hb000_0000, 4'h5, 1'b0);
		vds_far_model_inst.push(1, 32'hb000_0001, 4'h5, 1'b0);
		vds_far_model_inst.push(2, 32'hb000_0002, 4'h5, 1'b1);
		run(32'h400);
		wait_err();
		chk_beat(0, 32'h3000, 32'he000_0000);
		chk_beat(1, 32'h3004, 32'he000_0001);
		chk_beat(2, 32'h4000, 32'hf000_0000);
		chk_beat(3, 32'h5000, 32'hb000_0000);
		chk_beat(4, 32'h6000, 32'hb000_0001);
		chk_beat(5, 32'h7000, 32'hb000_0002);
		chk(vds_far_model_inst.beats.size(), 6);
		reg_read(vds_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0001);
		// Chroma kept then dropped, planar discard, line end on a non-last write
		prog(32'h500, '{32'h8000_0006, 0, 32'hbc00_0004, 4, 32'h8000, 32'h8100, 32'h8200,
			32'hbc00_0004, 4, 32'h9000, 32'h9100, 32'h9200, 32'hac00_0004, 4,
			32'h1800_0004, 32'ha000, 32'h5400_0004, 32'h0});
		for (int i = 0; i < 9; i++)
		begin
			vds_far_model_inst.push(i % 3, 32'hc000_0000 + 32'(i), 4'h6, i % 3 == 2);
		end
		vds_far_model_inst.push(0, 32'hd000_0000, 4'h6, 1'b1);
		run(32'h500);
		wait_err();
		chk_beat(0, 32'h8000, 32'hc000_0000);
		chk_beat(1, 32'h8100, 32'hc000_0001);
		chk_beat(2, 32'h8200, 32'hc000_0002);
		chk_beat(3, 32'h9000, 32'hc000_0003);
		chk_beat(4, 32'ha000, 32'hd000_0000);
		chk(vds_far_model_inst.beats.size(), 5);
		reg_read(vds_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0003);
		conclude();
	end
endmodule : vds_sequencer_test

// *** vds_wbuf.sv ***
/*
 Instruction word buffer, one register per DWORD of the current instruction.
 Assumes words are written one at a time by the fetch logic.
*/
`timescale 1ns/1ps
module vds_wbuf #(
	parameter int DEPTH = vds_pkg::MAX_WORDS
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Write side
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [31:0] wr_data,
	// Registered words
	output logic [DEPTH-1:0][31:0] words
);

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_word
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					words[gi] <= 32'h0000_0000;
				else if (wr_en && wr_idx == 3'(gi))
					words[gi] <= wr_data;
			end
		end
	endgenerate

endmodule : vds_wbuf
